// ---- include/sutc_params.svh ----
// register map, field positions, reset values and sizes for the user buffer / tx control block
`ifndef SUTC_PARAMS_SVH
`define SUTC_PARAMS_SVH

`define SUTC_ADDR_W          7
`define SUTC_ADDR_RX_BCFG    7'h0b
`define SUTC_ADDR_TX_CTL     7'h0c

`define SUTC_RX_BCFG_RST     8'h00
`define SUTC_TX_CTL_RST      8'h00
`define SUTC_RX_BCFG_MASK    8'h3f
`define SUTC_TX_CTL_MASK     8'h7f

`define SUTC_BCFG_DAT_ONLY   5
`define SUTC_BCFG_SPLIT      4
`define SUTC_BCFG_CS_MODE    3
`define SUTC_BCFG_MODE_HI    2
`define SUTC_BCFG_MODE_LO    1
`define SUTC_BCFG_SIZE       0

`define SUTC_CTL_VALID       6
`define SUTC_CTL_RATIO_HI    5
`define SUTC_CTL_RATIO_LO    3
`define SUTC_CTL_CLK_HI      2
`define SUTC_CTL_CLK_LO      1
`define SUTC_CTL_EN          0

`define SUTC_RATIO_1_1       3'h0
`define SUTC_RATIO_1_2       3'h1
`define SUTC_RATIO_1_4       3'h2
`define SUTC_RATIO_2_1       3'h5
`define SUTC_RATIO_4_1       3'h6
`define SUTC_MUL_X1          2'h0
`define SUTC_MUL_X2          2'h1
`define SUTC_MUL_X4          2'h2

`define SUTC_CS_BYTES_W      40
`define SUTC_UBUF_CNT_W      10
`define SUTC_UBUF_LEN_SMALL  10'h180
`define SUTC_UBUF_LEN_LARGE  10'h300

`define SUTC_SPI_FRAME_BITS  5'h10
`define SUTC_SPI_HDR_BITS    5'h08
`define SUTC_SPI_RW_BIT      0

`endif

// ---- include/sutc_pkg.sv ----
// types shared by the user buffer / tx control block
package sutc_pkg;

	typedef enum logic [1:0] {
		SUTC_UB_DISCARD,
		SUTC_UB_DOUBLE,
		SUTC_UB_FORMAT,
		SUTC_UB_RSVD
	} sutc_ubuf_mode_e;

	typedef enum logic [1:0] {
		SUTC_CLK_INT1,
		SUTC_CLK_INT2,
		SUTC_CLK_PLL,
		SUTC_CLK_RSVD
	} sutc_clk_src_e;

endpackage

// ---- hdl/sutc_spi_port.sv ----
// serial control port slave: 7-bit address, read flag, 8 data bits, msb first, mode 0
`timescale 1ns/10ps
`default_nettype none
`include "sutc_params.svh"

module sutc_spi_port (
	input  wire logic                    clk_sys,
	input  wire logic                    srst,
	input  wire logic                    spi_sclk,
	input  wire logic                    spi_cs_n,
	input  wire logic                    spi_mosi,
	output logic                         spi_miso,
	output logic                         spi_miso_oe_n,
	output logic                         wr_stb,
	output logic [`SUTC_ADDR_W-1:0]      reg_addr,
	output logic [7:0]                   wr_data,
	input  wire logic [7:0]              rd_data
);

	logic [2:0] sclk_q;
	logic [1:0] cs_n_q;
	logic [1:0] mosi_q;
	logic [4:0] bit_cnt_q;
	logic [14:0] shin_q;
	logic [7:0] shout_q;
	logic       reading_q;
	logic       fetch_q;
	logic       load_q;
	logic       rise;
	logic       fall;

	// sclk_q[0], cs_n_q[0], mosi_q[0] are first synchroniser stages, read only by the next stage
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			sclk_q <= 3'h0;
			cs_n_q <= 2'h3;
			mosi_q <= 2'h0;
		end else begin
			sclk_q <= {sclk_q[1:0], spi_sclk};
			cs_n_q <= {cs_n_q[0], spi_cs_n};
			mosi_q <= {mosi_q[0], spi_mosi};
		end
	end

	assign rise = sclk_q[1] & ~sclk_q[2];
	assign fall = ~sclk_q[1] & sclk_q[2];

	always_ff @(posedge clk_sys) begin
		if (srst || cs_n_q[1]) begin
			bit_cnt_q <= 5'h00;
			shin_q    <= 15'h0000;
		end else if (rise && bit_cnt_q != `SUTC_SPI_FRAME_BITS) begin
			bit_cnt_q <= bit_cnt_q + 5'h01;
			shin_q    <= {shin_q[13:0], mosi_q[1]};
		end
	end

	// address and direction are complete at the eighth rise; the shifter loads two cycles
	// later because the read register needs one cycle to follow the new address
	always_ff @(posedge clk_sys) begin
		if (srst || cs_n_q[1]) begin
			reading_q <= 1'b0;
			fetch_q   <= 1'b0;
			load_q    <= 1'b0;
			reg_addr  <= {`SUTC_ADDR_W{1'b0}};
		end else begin
			fetch_q <= 1'b0;
			load_q  <= fetch_q;
			if (rise && bit_cnt_q == `SUTC_SPI_HDR_BITS - 5'h01) begin
				reg_addr  <= shin_q[`SUTC_ADDR_W-1:0];
				reading_q <= mosi_q[1];
				fetch_q   <= mosi_q[1];
			end
		end
	end

	// miso changes on falling sclk so the master samples a settled bit on the rising one
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			shout_q       <= 8'h00;
			spi_miso      <= 1'b0;
			spi_miso_oe_n <= 1'b1;
		end else begin
			spi_miso_oe_n <= ~(reading_q & ~cs_n_q[1]);
			if (load_q) begin
				shout_q  <= {rd_data[6:0], 1'b0};
				spi_miso <= rd_data[7];
			end else if (fall && reading_q && bit_cnt_q > `SUTC_SPI_HDR_BITS) begin
				shout_q  <= {shout_q[6:0], 1'b0};
				spi_miso <= shout_q[7];
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			wr_stb  <= 1'b0;
			wr_data <= 8'h00;
		end else begin
			wr_stb <= rise && !cs_n_q[1] && !reading_q && bit_cnt_q == `SUTC_SPI_FRAME_BITS - 5'h01;
			if (rise && bit_cnt_q == `SUTC_SPI_FRAME_BITS - 5'h01) begin
				wr_data <= {shin_q[6:0], mosi_q[1]};
			end
		end
	end

endmodule
`default_nettype wire

// ---- hdl/sutc_ctrl.sv ----
// receive user-bit buffer configuration and transmitter control registers with their effects
//
// Summary of operation
// - with the dat-only option set, iec formatting in use and dat category seen, the user-bit interrupt fires only on a start bit change.
// - the split bit keeps channel a and b user bits together at 0 and apart at 1.
// - with the cs interrupt mode at 0 the cs block flag sets on every new 192-frame block.
// - with the cs interrupt mode at 1 the flag sets only when the first five cs bytes differ from the previous block.
// - user-buffer mode 00 discards user bits, 01 fills the second buffer once the first is full, 11 is reserved.
// - user-buffer mode 10 formats by cs byte 1 bits 4 to 7 when professional, otherwise by the consumer user-data format.
// - the validity control drives the outgoing validity bit, 1 meaning unsuitable for conversion.
// - ratio codes 000, 001 and 010 select 1:1, 1:2 and 1:4.
// - ratio codes 101 and 110 select 2:1 and 4:1, any other code is unsupported.
// - clock select 00, 01, 10 pick internal clock 1, internal clock 2 and the recovered pll clock, 11 is reserved.
// - the transmitter streams only while its enable bit is 1.
// - the receive buffer configuration register sits at 0x0b with bits 7 and 6 reserved.
// - the transmit control register sits at 0x0c with validity, ratio, clock select and enable fields.
`timescale 1ns/10ps
`default_nettype none
`include "sutc_params.svh"

module sutc_ctrl (
	input  wire logic                        clk_sys,
	input  wire logic                        srst,
	input  wire logic                        spi_sclk,
	input  wire logic                        spi_cs_n,
	input  wire logic                        spi_mosi,
	output logic                             spi_miso,
	output logic                             spi_miso_oe_n,
	input  wire logic                        cs_block_done,
	input  wire logic [`SUTC_CS_BYTES_W-1:0] cs_first_bytes,
	input  wire logic                        rx_cs_flag_clr,
	input  wire logic                        professional_flag,
	input  wire logic                        dat_category,
	input  wire logic                        user_evt,
	input  wire logic                        user_id_change,
	input  wire logic                        user_bit_stb,
	input  wire logic                        user_preamble_z,
	output logic                             rx_cs_block_flag,
	output logic                             user_bit_irq,
	output logic                             rx_user_wr,
	output logic                             rx_user_buf_sel,
	output logic                             rx_user_split,
	output logic                             rx_fmt_pro,
	output logic                             rx_fmt_iec,
	output logic                             tx_validity_ctl,
	output logic                             tx_ratio_valid,
	output logic [1:0]                       tx_rate_mul,
	output logic                             tx_rate_up,
	output logic [2:0]                       tx_clk_sel,
	output logic                             tx_stream_en
);

	logic                        wr_stb;
	logic [`SUTC_ADDR_W-1:0]     reg_addr;
	logic [7:0]                  wr_data;
	logic [7:0]                  rd_data_q;
	logic [7:0]                  rx_bcfg_q;
	logic [7:0]                  tx_ctl_q;
	logic [`SUTC_CS_BYTES_W-1:0] cs_prev_q;
	logic [`SUTC_UBUF_CNT_W-1:0] ub_cnt_q;
	logic                        ub_run_q;
	sutc_pkg::sutc_ubuf_mode_e   ub_mode;
	sutc_pkg::sutc_clk_src_e     clk_src;
	logic [2:0]                  ratio;
	logic                        iec_fmt;
	logic                        dat_gate;
	logic                        cs_set;

	sutc_spi_port u_spi (
		.clk_sys       (clk_sys),
		.srst          (srst),
		.spi_sclk      (spi_sclk),
		.spi_cs_n      (spi_cs_n),
		.spi_mosi      (spi_mosi),
		.spi_miso      (spi_miso),
		.spi_miso_oe_n (spi_miso_oe_n),
		.wr_stb        (wr_stb),
		.reg_addr      (reg_addr),
		.wr_data       (wr_data),
		.rd_data       (rd_data_q)
	);

	function automatic logic [`SUTC_UBUF_CNT_W-1:0] ubuf_last(input logic big);
		ubuf_last = (big ? `SUTC_UBUF_LEN_LARGE : `SUTC_UBUF_LEN_SMALL) - 10'h001;
	endfunction

	assign ub_mode = sutc_pkg::sutc_ubuf_mode_e'(rx_bcfg_q[`SUTC_BCFG_MODE_HI:`SUTC_BCFG_MODE_LO]);
	assign clk_src = sutc_pkg::sutc_clk_src_e'(tx_ctl_q[`SUTC_CTL_CLK_HI:`SUTC_CTL_CLK_LO]);
	assign ratio   = tx_ctl_q[`SUTC_CTL_RATIO_HI:`SUTC_CTL_RATIO_LO];
	assign iec_fmt = (ub_mode == sutc_pkg::SUTC_UB_FORMAT) && !professional_flag;
	assign dat_gate = rx_bcfg_q[`SUTC_BCFG_DAT_ONLY] && iec_fmt && dat_category;

	// reserved bits are dropped on write so they always read back as zero
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rx_bcfg_q <= `SUTC_RX_BCFG_RST;
			tx_ctl_q  <= `SUTC_TX_CTL_RST;
		end else if (wr_stb) begin
			if (reg_addr == `SUTC_ADDR_RX_BCFG) begin
				rx_bcfg_q <= wr_data & `SUTC_RX_BCFG_MASK;
			end
			if (reg_addr == `SUTC_ADDR_TX_CTL) begin
				tx_ctl_q <= wr_data & `SUTC_TX_CTL_MASK;
			end
		end
	end

	// unmapped addresses read as zero
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rd_data_q <= 8'h00;
		end else if (reg_addr == `SUTC_ADDR_RX_BCFG) begin
			rd_data_q <= rx_bcfg_q;
		end else if (reg_addr == `SUTC_ADDR_TX_CTL) begin
			rd_data_q <= tx_ctl_q;
		end else begin
			rd_data_q <= 8'h00;
		end
	end

	// the compare history updates on every block so mode 1 always compares against the last one
	assign cs_set = cs_block_done &&
		(!rx_bcfg_q[`SUTC_BCFG_CS_MODE] || cs_first_bytes != cs_prev_q);

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			cs_prev_q        <= {`SUTC_CS_BYTES_W{1'b0}};
			rx_cs_block_flag <= 1'b0;
		end else begin
			if (cs_block_done) begin
				cs_prev_q <= cs_first_bytes;
			end
			// a set in the clearing cycle wins
			if (cs_set) begin
				rx_cs_block_flag <= 1'b1;
			end else if (rx_cs_flag_clr) begin
				rx_cs_block_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			user_bit_irq <= 1'b0;
		end else begin
			user_bit_irq <= dat_gate ? user_id_change : user_evt;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rx_user_split <= 1'b0;
			rx_fmt_pro    <= 1'b0;
			rx_fmt_iec    <= 1'b0;
		end else begin
			rx_user_split <= rx_bcfg_q[`SUTC_BCFG_SPLIT];
			rx_fmt_pro    <= (ub_mode == sutc_pkg::SUTC_UB_FORMAT) && professional_flag;
			rx_fmt_iec    <= iec_fmt;
		end
	end

	// double buffering: count bits from preamble z and swap buffers when the selected length fills
	always_ff @(posedge clk_sys) begin
		if (srst || ub_mode != sutc_pkg::SUTC_UB_DOUBLE) begin
			ub_cnt_q        <= {`SUTC_UBUF_CNT_W{1'b0}};
			ub_run_q        <= 1'b0;
			rx_user_buf_sel <= 1'b0;
		end else if (user_bit_stb && (ub_run_q || user_preamble_z)) begin
			ub_run_q <= 1'b1;
			if (ub_cnt_q == ubuf_last(rx_bcfg_q[`SUTC_BCFG_SIZE])) begin
				ub_cnt_q        <= {`SUTC_UBUF_CNT_W{1'b0}};
				rx_user_buf_sel <= ~rx_user_buf_sel;
			end else begin
				ub_cnt_q <= ub_cnt_q + 10'h001;
			end
		end
	end

	// user bits are stored in modes 01 and 10; 00 and the reserved code discard them
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			rx_user_wr <= 1'b0;
		end else begin
			unique case (ub_mode)
				sutc_pkg::SUTC_UB_DISCARD: rx_user_wr <= 1'b0;
				sutc_pkg::SUTC_UB_DOUBLE:  rx_user_wr <= user_bit_stb && (ub_run_q || user_preamble_z);
				sutc_pkg::SUTC_UB_FORMAT:  rx_user_wr <= user_bit_stb;
				sutc_pkg::SUTC_UB_RSVD:    rx_user_wr <= 1'b0;
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			tx_ratio_valid <= 1'b0;
			tx_rate_mul    <= `SUTC_MUL_X1;
			tx_rate_up     <= 1'b0;
		end else begin
			tx_ratio_valid <= 1'b1;
			tx_rate_up     <= 1'b0;
			tx_rate_mul    <= `SUTC_MUL_X1;
			case (ratio)
				`SUTC_RATIO_1_1: tx_rate_mul <= `SUTC_MUL_X1;
				`SUTC_RATIO_1_2: tx_rate_mul <= `SUTC_MUL_X2;
				`SUTC_RATIO_1_4: tx_rate_mul <= `SUTC_MUL_X4;
				`SUTC_RATIO_2_1: begin
					tx_rate_mul <= `SUTC_MUL_X2;
					tx_rate_up  <= 1'b1;
				end
				`SUTC_RATIO_4_1: begin
					tx_rate_mul <= `SUTC_MUL_X4;
					tx_rate_up  <= 1'b1;
				end
				default: tx_ratio_valid <= 1'b0;
			endcase
		end
	end

	// reserved clock code selects nothing rather than guessing a source
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			tx_clk_sel      <= 3'h0;
			tx_validity_ctl <= 1'b0;
			tx_stream_en    <= 1'b0;
		end else begin
			unique case (clk_src)
				sutc_pkg::SUTC_CLK_INT1: tx_clk_sel <= 3'h1;
				sutc_pkg::SUTC_CLK_INT2: tx_clk_sel <= 3'h2;
				sutc_pkg::SUTC_CLK_PLL:  tx_clk_sel <= 3'h4;
				sutc_pkg::SUTC_CLK_RSVD: tx_clk_sel <= 3'h0;
			endcase
			tx_validity_ctl <= tx_ctl_q[`SUTC_CTL_VALID];
			tx_stream_en    <= tx_ctl_q[`SUTC_CTL_EN];
		end
	end

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (srst);

	sequence ctl_write_s;
		wr_stb && reg_addr == `SUTC_ADDR_TX_CTL;
	endsequence

	sequence ctl_settle_s;
		##2 1'b1;
	endsequence

	cs_every_block_a: assert property (
		cs_block_done && !rx_bcfg_q[`SUTC_BCFG_CS_MODE] |=> rx_cs_block_flag)
		else $error("cs flag not set on a new block");
	cs_same_bytes_a: assert property (
		cs_block_done && rx_bcfg_q[`SUTC_BCFG_CS_MODE] && cs_first_bytes == cs_prev_q
		&& !rx_cs_block_flag |=> !rx_cs_block_flag)
		else $error("cs flag set although first bytes unchanged");
	cs_changed_a: assert property (
		cs_block_done && cs_first_bytes != cs_prev_q |=> rx_cs_block_flag)
		else $error("cs flag missed on changed bytes");
	dat_irq_gate_a: assert property (
		dat_gate && !user_id_change |=> !user_bit_irq)
		else $error("user irq fired without a start bit change");
	user_discard_a: assert property (
		ub_mode == sutc_pkg::SUTC_UB_DISCARD |=> !rx_user_wr)
		else $error("user bit stored in discard mode");
	split_follow_a: assert property (
		##1 rx_user_split == $past(rx_bcfg_q[`SUTC_BCFG_SPLIT]))
		else $error("split output does not follow config");
	pro_format_a: assert property (
		ub_mode == sutc_pkg::SUTC_UB_FORMAT |=> rx_fmt_pro != rx_fmt_iec)
		else $error("format selection not exclusive");
	ratio_bad_a: assert property (
		ratio inside {3'h3, 3'h4, 3'h7} |=> !tx_ratio_valid)
		else $error("unsupported ratio reported valid");
	ratio_unity_a: assert property (
		ratio == `SUTC_RATIO_1_1 |=> tx_ratio_valid && tx_rate_mul == `SUTC_MUL_X1 && !tx_rate_up)
		else $error("unity ratio decoded wrong");
	clk_reserved_a: assert property (
		clk_src == sutc_pkg::SUTC_CLK_RSVD |=> tx_clk_sel == 3'h0)
		else $error("reserved clock code selects a source");
	enable_write_a: assert property (
		ctl_write_s ##0 ctl_settle_s |-> tx_stream_en == $past(wr_data[`SUTC_CTL_EN], 2))
		else $error("transmitter enable does not follow write");
	validity_write_a: assert property (
		ctl_write_s ##0 ctl_settle_s |-> tx_validity_ctl == $past(wr_data[`SUTC_CTL_VALID], 2))
		else $error("validity does not follow write");
	bcfg_reserved_a: assert property (
		rx_bcfg_q[7:6] == 2'h0)
		else $error("reserved config bits not zero");

endmodule
`default_nettype wire

// ---- tb/sutc_host_model.sv ----
// serial control host model: mode 0 frames of 7-bit address, read flag and one data byte
`timescale 1ns/10ps
`default_nettype none

module sutc_host_model #(
	parameter int HALF = 8
) (
	input  wire logic clk_sys,
	output var logic  spi_sclk,
	output var logic  spi_cs_n,
	output var logic  spi_mosi,
	input  wire logic spi_miso,
	input  wire logic spi_miso_oe_n
);
	initial begin
		spi_sclk = 1'b0;
		spi_cs_n = 1'b1;
		spi_mosi = 1'b0;
	end

	// half period of 8 clocks leaves room for the two-flop synchroniser and the miso update
	task automatic xfer(input logic [6:0] a, input logic rd, input logic [7:0] d,
	                    output logic [7:0] q);
		logic [15:0] f;
		f = {a, rd, d};
		q = 8'h00;
		@(posedge clk_sys) spi_cs_n <= 1'b0;
		for (int i = 15; i >= 0; i--) begin
			spi_mosi <= f[i];
			repeat (HALF) @(posedge clk_sys);
			// an undriven miso must not pass for data
			if (i < 8) q[i] = (spi_miso_oe_n === 1'b0) ? spi_miso : 1'bx;
			spi_sclk <= 1'b1;
			repeat (HALF) @(posedge clk_sys);
			spi_sclk <= 1'b0;
		end
		repeat (HALF) @(posedge clk_sys);
		spi_cs_n <= 1'b1;
		// deselected: flip mosi so nothing can lean on a held value
		spi_mosi <= ~spi_mosi;
		repeat (HALF) @(posedge clk_sys);
	endtask
endmodule
`default_nettype wire

// ---- tb/testbench.sv ----
// self-checking bench for the user buffer configuration and transmitter control block
`timescale 1ns/10ps
`default_nettype none
`include "sutc_params.svh"

module testbench;
	logic        clk_sys         = 1'b0;
	logic        srst            = 1'b1;
	logic [4:0]  ev              = 5'h00;
	logic [39:0] cs_first_bytes  = 40'h0;
	logic        professional_flag = 1'b0;
	logic        dat_category    = 1'b0;
	logic        user_preamble_z = 1'b0;
	wire         spi_sclk, spi_cs_n, spi_mosi, spi_miso, spi_miso_oe_n;
	wire         rx_cs_block_flag, user_bit_irq, rx_user_wr, rx_user_buf_sel, rx_user_split;
	wire         rx_fmt_pro, rx_fmt_iec, tx_validity_ctl, tx_ratio_valid, tx_rate_up;
	wire         tx_stream_en;
	wire [1:0]   tx_rate_mul;
	wire [2:0]   tx_clk_sel;
	int          num_errors, compares, bcfg, ctl, n_wr, n_irq, e_wr, e_irq;
	logic [39:0] hist = 40'h0;
	logic        e_flag = 1'b0;

	always #20 clk_sys = ~clk_sys;

	sutc_host_model host (.clk_sys(clk_sys), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n));

	sutc_ctrl dut (.clk_sys(clk_sys), .srst(srst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe_n(spi_miso_oe_n),
		.cs_block_done(ev[0]), .cs_first_bytes(cs_first_bytes), .rx_cs_flag_clr(ev[1]),
		.professional_flag(professional_flag), .dat_category(dat_category),
		.user_evt(ev[2]), .user_id_change(ev[3]), .user_bit_stb(ev[4]),
		.user_preamble_z(user_preamble_z), .rx_cs_block_flag(rx_cs_block_flag),
		.user_bit_irq(user_bit_irq), .rx_user_wr(rx_user_wr), .rx_user_buf_sel(rx_user_buf_sel),
		.rx_user_split(rx_user_split), .rx_fmt_pro(rx_fmt_pro), .rx_fmt_iec(rx_fmt_iec),
		.tx_validity_ctl(tx_validity_ctl), .tx_ratio_valid(tx_ratio_valid),
		.tx_rate_mul(tx_rate_mul), .tx_rate_up(tx_rate_up), .tx_clk_sel(tx_clk_sel),
		.tx_stream_en(tx_stream_en));

	always @(posedge clk_sys) begin
		if (rx_user_wr === 1'b1) n_wr++;
		if (user_bit_irq === 1'b1) n_irq++;
	end

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
		compares++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic chk_n(input int got, input int exp, input string what);
		compares++;
		if (got != exp) begin
			num_errors++;
			$display("BAD t=%0t %s count %0d exp %0d", $time, what, got, exp);
		end
	endtask

	function automatic logic [7:0] tx_exp(input int c);
		int         r;
		int         k;
		logic [1:0] m;
		r = (c >> 3) & 7;
		k = (c >> 1) & 3;
		m = (r == 1 || r == 5) ? 2'h1 : (r == 2 || r == 6) ? 2'h2 : 2'h0;
		return {c[6], (r inside {0, 1, 2, 5, 6}), m, (r == 5 || r == 6),
			(k == 3) ? 3'h0 : 3'(1 << k)};
	endfunction

	task automatic outs();
		int         md;
		logic [7:0] t;
		logic [7:0] e;
		md = (bcfg >> 1) & 3;
		repeat (3) @(posedge clk_sys);
		t = {tx_validity_ctl, tx_ratio_valid, tx_rate_mul, tx_rate_up, tx_clk_sel};
		chk(t, tx_exp(ctl), "tx");
		t = {4'h0, rx_user_split, rx_fmt_pro, rx_fmt_iec, tx_stream_en};
		e = {4'h0, bcfg[4], (md == 2 && professional_flag), (md == 2 && !professional_flag), ctl[0]};
		chk(t, e, "rx");
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		logic [7:0] q;
		host.xfer(a, 1'b0, d, q);
		if (a == `SUTC_ADDR_RX_BCFG) bcfg = d & `SUTC_RX_BCFG_MASK;
		if (a == `SUTC_ADDR_TX_CTL) ctl = d & `SUTC_TX_CTL_MASK;
		outs();
	endtask

	task automatic rd(input logic [6:0] a);
		logic [7:0] q;
		host.xfer(a, 1'b1, 8'h00, q);
		chk(q, a == `SUTC_ADDR_RX_BCFG ? 8'(bcfg) : a == `SUTC_ADDR_TX_CTL ? 8'(ctl) : 8'h00, "rd");
	endtask

	// one-cycle event pulse, then two edges so the registered answer has landed
	task automatic pls(input int k);
		ev <= 5'(1 << k);
		@(posedge clk_sys);
		ev <= 5'h00;
		repeat (2) @(posedge clk_sys);
	endtask

	task automatic blk(input logic [39:0] b);
		cs_first_bytes <= b;
		if (!bcfg[3] || b != hist) e_flag = 1'b1;
		hist = b;
		pls(0);
		chk({7'h0, rx_cs_block_flag}, {7'h0, e_flag}, "cs flag");
	endtask

	task automatic flag_clr();
		pls(1);
		e_flag = 1'b0;
		chk({7'h0, rx_cs_block_flag}, 8'h00, "cs clear");
	endtask

	task automatic ub(input logic z);
		user_preamble_z <= z;
		pls(4);
	endtask

	initial begin
		repeat (60000) @(posedge clk_sys);
		num_errors++;
		wrap_up();
	end

	initial begin
		logic [39:0] b;
		logic [7:0]  d;
		void'($urandom(32'h0ccd));
		repeat (8) @(posedge clk_sys);
		srst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		outs();
		rd(`SUTC_ADDR_RX_BCFG);
		rd(`SUTC_ADDR_TX_CTL);
		// reserved bits written as ones on purpose, they must read back as zero
		wr(`SUTC_ADDR_RX_BCFG, 8'hff);
		rd(`SUTC_ADDR_RX_BCFG);
		wr(`SUTC_ADDR_TX_CTL, 8'hff);
		rd(`SUTC_ADDR_TX_CTL);
		wr(7'h0d, 8'h5a);
		rd(7'h0d);
		rd(`SUTC_ADDR_TX_CTL);
		for (int i = 0; i < 8; i++) begin
			d = (8'($urandom) & 8'h40) | 8'(i << 3) | 8'((i & 3) << 1) | 8'(i & 1);
			wr(`SUTC_ADDR_TX_CTL, d);
		end
		wr(`SUTC_ADDR_RX_BCFG, 8'h14);
		professional_flag <= 1'b1;
		outs();
		for (int i = 0; i < 8; i++) begin
			if (i % 4 == 0) wr(`SUTC_ADDR_RX_BCFG, i < 4 ? 8'h24 : 8'h04);
			professional_flag <= i[0];
			dat_category <= i[1];
			repeat (3) @(posedge clk_sys);
			e_irq = n_irq + 1;
			pls(2);
			if (i == 2) pls(3);
			chk_n(n_irq, e_irq, "irq");
		end
		b = {8'($urandom), 32'($urandom)};
		wr(`SUTC_ADDR_RX_BCFG, 8'h00);
		blk(b);
		flag_clr();
		blk(b);
		flag_clr();
		wr(`SUTC_ADDR_RX_BCFG, 8'h08);
		blk(b);
		blk(~b);
		flag_clr();
		blk(~b);
		// size 0 then size 1; mode stays 01 so the second run starts from a wrapped count
		for (int s = 0; s < 2; s++) begin
			wr(`SUTC_ADDR_RX_BCFG, s ? 8'h03 : 8'h02);
			e_wr = n_wr;
			if (s == 0) repeat (3) ub(1'b0);
			chk_n(n_wr, e_wr, "wr before z");
			for (int i = 0; i < 384 * (s + 1); i++) begin
				if (i == 384 * (s + 1) - 1) chk(8'(rx_user_buf_sel), 8'(s), "sel early");
				ub(i == 0);
			end
			chk_n(n_wr, e_wr + 384 * (s + 1), "wr count");
			chk(8'(rx_user_buf_sel), 8'(1 - s), "sel swap");
		end
		for (int m = 0; m < 2; m++) begin
			wr(`SUTC_ADDR_RX_BCFG, m ? 8'h06 : 8'h00);
			e_wr = n_wr;
			repeat (5) ub(1'b1);
			chk_n(n_wr, e_wr, "wr dropped");
		end
		wrap_up();
	end
endmodule
`default_nettype wire
